// ===== bench/freq_ref_asserts.sv
// Port checks of the reference selector
`timescale 1ns/1ps
`default_nettype none
module freq_ref_asserts
	import freq_ref_pkg::*;
(
	input wire logic clock, // Clock
	input wire logic reset_n, // Reset
	input wire logic [freq_ref_pkg::ADDR_W-1:0] address, // Index
	input wire logic [freq_ref_pkg::DATA_W-1:0] write_data, // Wdata
	input wire logic write_strobe, // Write
	input wire logic read_strobe, // Read
	input wire logic [freq_ref_pkg::DATA_W-1:0] read_data, // Rdata
	input wire freq_ref_pkg::fe_in_s fe, // Front end
	input wire logic inc_pin, // Up
	input wire logic dec_pin, // Down
	input wire logic sleeping, // Asleep
	input wire logic [15:0] freq_ref, // Reference
	input wire logic [15:0] pid_bounded, // Bounded PID
	input wire freq_ref_pkg::flags_s flags, // Flags
	input wire logic comm_save // Persist
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence rd_of(logic [3:0] a);
		read_strobe && address == a;
	endsequence
	rd_idle_a: assert property (!$past(read_strobe) |->
		read_data == 32'h0)
		else $error("read data not idle");
	ref_read_a: assert property (rd_of(REG_REF) |=>
		read_data == {16'h0, $past(freq_ref)})
		else $error("reference read wrong");
	status_read_a: assert property (rd_of(REG_STATUS) |=>
		read_data == {28'h0, $past(flags)})
		else $error("status read wrong");
	unmapped_read_a: assert property (rd_of(4'hE) |=>
		read_data == 32'h0)
		else $error("unmapped read not zero");
	save_cause_a: assert property (comm_save |->
		$past(fe.comm_valid))
		else $error("save without new value");
	save_mode_a: assert property (comm_save |->
		flags.comm_shown)
		else $error("save outside serial mode");
	pid_awake_a: assert property (!$past(sleeping) |->
		pid_bounded == $past(fe.pid_in))
		else $error("pid altered while awake");
	pid_floor_a: assert property ($past(sleeping) |->
		pid_bounded >= $past(fe.pid_in))
		else $error("pid below input while asleep");
endmodule // freq_ref_asserts
`default_nettype wire

// ===== bench/freq_ref_selector_tb.sv
// Self-checking bench of the reference selector
`timescale 1ns/1ps
`default_nettype none
module freq_ref_selector_tb;
	import freq_ref_pkg::*;
	logic clock, reset_n, write_strobe, read_strobe, sleeping, comm_save;
	logic inc_pin, dec_pin;
	logic [ADDR_W-1:0] address;
	logic [DATA_W-1:0] write_data, read_data;
	logic [15:0] freq_ref, pid_bounded;
	fe_in_s fe;
	flags_s flags;
	int err_count, comparisons;
	freq_ref_selector #(.TICK_CYC(4)) dut (.clock(clock), .reset_n(reset_n),
		.address(address), .write_data(write_data), .write_strobe(write_strobe),
		.read_strobe(read_strobe), .read_data(read_data), .fe(fe),
		.inc_pin(inc_pin), .dec_pin(dec_pin), .sleeping(sleeping),
		.freq_ref(freq_ref), .pid_bounded(pid_bounded), .flags(flags),
		.comm_save(comm_save));
	front_end_model fem (.clock(clock), .fe(fe), .inc_pin(inc_pin),
		.dec_pin(dec_pin));
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		address <= a;
		write_data <= d;
		write_strobe <= 1'b1;
		@(posedge clock);
		write_strobe <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clock);
		address <= a;
		read_strobe <= 1'b1;
		@(posedge clock);
		read_strobe <= 1'b0;
		#1 chk(read_data, e);
	endtask
	task automatic ref_is(input logic [15:0] e);
		repeat (3) @(posedge clock);
		#1 chk({16'h0, freq_ref}, {16'h0, e});
	endtask
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial
	begin
		#400000;
		err_count++;
		end_of_test();
	end
	initial
	begin
		reset_n = 1'b0;
		address = '0;
		write_data = '0;
		write_strobe = 1'b0;
		read_strobe = 1'b0;
		sleeping = 1'b0;
		repeat (16) @(posedge clock);
		reset_n <= 1'b1;
		rd(REG_CTRL, {7'h0, CTRL_RST});
		rd(REG_FMIN1, {16'h0, FMIN_RST});
		wr(REG_UPPER, 32'h0);
		rd(REG_UPPER, {21'h0, UPPER_RST});
		rd(4'hE, 32'h0);
		wr(REG_KEYPAD, 32'h03E8);
		ref_is(16'h03E8);
		rd(REG_REF, 32'h03E8);
		$display("keypad test done");
		wr(REG_STAGE0, 32'h02BC);
		wr(REG_CTRL, 32'h1903);
		fem.comm(16'h01F4);
		#1 chk({31'h0, comm_save}, 32'h1);
		ref_is(16'h04B0);
		rd(REG_COMM, 32'h01F4);
		rd(REG_STATUS, 32'h1);
		fem.restore(16'h0258);
		ref_is(16'h0514);
		rd(REG_COMM, 32'h0258);
		wr(REG_CTRL, 32'h1100);
		rd(REG_STATUS, 32'h8);
		$display("combine test done");
		wr(REG_KEYPAD, 32'h0064);
		wr(REG_CTRL, 32'h1000);
		ref_is(16'h0064);
		rd(REG_STATUS, 32'h2);
		wr(REG_CTRL, 32'h1200);
		ref_is(16'h0096);
		$display("minimum test done");
		wr(REG_CTRL, 32'h1000);
		wr(REG_KEYPAD, 32'h0FA0);
		wr(REG_UPPER, 32'h01F4);
		ref_is(16'h0BB8);
		wr(REG_UPPER, 32'h03E8);
		wr(REG_LOWER, 32'h0258);
		wr(REG_KEYPAD, 32'h03E8);
		ref_is(16'h0E10);
		wr(REG_UPPER, 32'h01F4);
		ref_is(16'h0BB8);
		rd(REG_STATUS, 32'h4);
		fem.levels(12'h0, 12'h400, 16'h09C4, 16'h03E8, 16'h0064);
		sleeping <= 1'b1;
		repeat (3) @(posedge clock);
		#1 chk({16'h0, pid_bounded}, 32'h0E10);
		wr(REG_CTRL, 32'h1400);
		repeat (3) @(posedge clock);
		#1 chk({16'h0, pid_bounded}, 32'h0064);
		@(posedge clock) sleeping <= 1'b0;
		$display("limit test done");
		wr(REG_UPPER, 32'h03E8);
		wr(REG_LOWER, 32'h0);
		wr(REG_KEYPAD, 32'h0FA0);
		wr(REG_FMAX2, 32'h0BB8);
		wr(REG_CTRL, 32'h1001000);
		ref_is(16'h0BB8);
		wr(REG_CTRL, 32'h1004);
		ref_is(16'h09C4);
		wr(REG_MPG_MAG, 32'h0200);
		wr(REG_MPG_LIMIT, 32'h05DC);
		wr(REG_CTRL, 32'h1008);
		ref_is(16'h05DC);
		$display("source test done");
		wr(REG_CTRL, 32'h0007);
		ref_is(16'h0BB8);
		wr(REG_CTRL, 32'hA0001);
		ref_is(16'h0BB8);
		wr(REG_CTRL, 32'hA0007);
		ref_is(16'h0);
		wr(REG_CTRL, 32'h1007);
		repeat (3) @(posedge clock);
		#1 chk({31'h0, freq_ref > 16'h08B0 && freq_ref < 16'h08E0}, 32'h1);
		wr(REG_CTRL, 32'h1002);
		fem.updown(1'b1, 1'b0);
		repeat (40) @(posedge clock);
		#1 chk({31'h0, freq_ref > 16'h6 && freq_ref < 16'hC}, 32'h1);
		fem.updown(1'b0, 1'b1);
		repeat (60) @(posedge clock);
		#1 chk({16'h0, freq_ref}, 32'h0);
		fem.updown(1'b0, 1'b0);
		$display("analog and terminal test done");
		end_of_test();
	end
endmodule // freq_ref_selector_tb
bind freq_ref_selector freq_ref_asserts chk_i (.clock(clock),
	.reset_n(reset_n), .address(address), .write_data(write_data),
	.write_strobe(write_strobe), .read_strobe(read_strobe),
	.read_data(read_data), .fe(fe), .inc_pin(inc_pin), .dec_pin(dec_pin),
	.sleeping(sleeping), .freq_ref(freq_ref), .pid_bounded(pid_bounded),
	.flags(flags), .comm_save(comm_save));
`default_nettype wire

// ===== bench/front_end_model.sv
// Front-end model: analog, pulse, serial and terminal inputs
`timescale 1ns/1ps
`default_nettype none
module front_end_model
	import freq_ref_pkg::*;
(
	input wire logic clock, // Clock
	output freq_ref_pkg::fe_in_s fe, // Front-end values
	output logic inc_pin, // Up terminal
	output logic dec_pin // Down terminal
);
	initial
	begin
		fe = '0;
		inc_pin = 1'b0;
		dec_pin = 1'b0;
	end
	task automatic comm(input logic [15:0] f);
		@(posedge clock);
		fe.comm_freq <= f;
		fe.comm_valid <= 1'b1;
		@(posedge clock);
		fe.comm_valid <= 1'b0;
	endtask
	task automatic restore(input logic [15:0] f);
		@(posedge clock);
		fe.restore_freq <= f;
		fe.restore_valid <= 1'b1;
		@(posedge clock);
		fe.restore_valid <= 1'b0;
	endtask
	task automatic levels(input logic [11:0] a1, input logic [11:0] a2,
		input logic [15:0] p, input logic [15:0] m, input logic [15:0] pid);
		@(posedge clock);
		fe.ai1 <= a1;
		fe.ai2 <= a2;
		fe.pulse_hz <= p;
		fe.mpg_speed <= m;
		fe.pid_in <= pid;
	endtask
	// Both terminals always assigned
	task automatic updown(input logic up, input logic dn);
		@(posedge clock);
		inc_pin <= up;
		dec_pin <= dn;
	endtask
endmodule // front_end_model
`default_nettype wire

// ===== design/freq_ref_selector.sv
// Frequency reference selection, combination and limiting
// Summary of operation
// R01 - Code 0: main uses keypad entry, alternative uses speed-stage-0 value.
// R02 - Analog type 0..5 sets input pair ranges; default 1.
// R03 - Code 1 uses analog one; second function 10 adds analog two.
// R04 - Code 2 ramps reference up on increment, down on decrement input.
// R05 - Configurer assigns increment and decrement terminals before selecting code 2.
// R06 - Code 3 takes reference from the serial communication port.
// R07 - Code 4 uses scaled pulse train when pulse function is 0.
// R08 - Code 7 with second function 0 uses analog two, full scale 100%.
// R09 - Code 7 with second function nonzero gives zero reference.
// R10 - Main code 8: hand-wheel speed times gain, clamped to limit.
// R11 - Combine mode 0 uses main only; 1 uses main plus alternative.
// R12 - Combine 1 with equal main and alternative codes flags error.
// R13 - Communication reference readable, 0 to 599.00 Hz, when code 3 used.
// R14 - Retention 1 keeps communication value; acts only in communication mode.
// R15 - Detection 0: command below motor one minimum raises warning.
// R16 - Detection 1: command below motor one minimum runs at minimum.
// R17 - Sleeping bounds controller output at lower limit or 0 Hz.
// R18 - Reference capped at upper limit, 0.1 to 109.0 percent.
// R19 - Reference held at or above lower limit, 0.0 to 109.0 percent.
// R20 - Percent limits use selected motor's maximum frequency.
// R21 - Upper limit below lower limit flags setting-range error.
// R22 - Limits apply in every source mode.
// R23 - Reference and flags registered together on the control clock.
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module freq_ref_selector
	import freq_ref_pkg::*;
#(
	parameter int TICK_CYC = UPDOWN_TICK_CYC
)
(
	input wire logic clock, // 50 MHz
	input wire logic reset_n, // Async reset
	input wire logic [freq_ref_pkg::ADDR_W-1:0] address, // Reg index
	input wire logic [freq_ref_pkg::DATA_W-1:0] write_data, // Write data
	input wire logic write_strobe, // Write
	input wire logic read_strobe, // Read
	output logic [freq_ref_pkg::DATA_W-1:0] read_data, // Read data
	input wire freq_ref_pkg::fe_in_s fe, // Front-end values
	input wire logic inc_pin, // Up terminal
	input wire logic dec_pin, // Down terminal
	input wire logic sleeping, // Drive asleep
	output logic [15:0] freq_ref, // Final reference
	output logic [15:0] pid_bounded, // Bounded PID
	output freq_ref_pkg::flags_s flags, // Error flags
	output logic comm_save // Persist pulse
);
	import freq_ref_pkg::*;

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [15:0] keypad;
		logic [15:0] stage0;
		logic [10:0] upper;
		logic [10:0] lower;
		logic [15:0] fmax1;
		logic [15:0] fmax2;
		logic [15:0] fmin1;
		logic [15:0] pulse_gain;
		logic [15:0] mpg_mag;
		logic [15:0] mpg_limit;
		logic [15:0] comm;
		logic [15:0] updown;
		logic [TICK_W-1:0] tick;
		logic [1:0] inc_sync;
		logic [1:0] dec_sync;
		logic [15:0] ref_q;
		logic [15:0] pid_q;
		flags_s flg;
		logic save;
		logic [DATA_W-1:0] rdata;
	} state_s;

	state_s st;
	state_s next_st;

	// ==========================================================
	// Helpers
	function automatic logic [11:0] ai_frac(
		input logic signed [11:0] raw,
		input ai_kind_e kind
	);
		logic [12:0] mag;
		logic [14:0] cur;
		mag = 13'h0000;
		cur = 15'h0000;
		ai_frac = 12'h000;
		case (kind)
			AI_UNI:
			begin
				if (!raw[11])
					ai_frac = {raw[10:0], 1'b0};
			end
			AI_BIP:
			begin
				mag = raw[11] ? 13'(-$signed({raw[11], raw})) : {1'b0, raw};
				ai_frac = (mag[12:11] != 2'b00) ? 12'hFFF : {mag[10:0], 1'b0};
			end
			AI_CUR:
			begin
				if (!raw[11] && raw[11:0] > MA4_CODE)
				begin
					cur = 15'((raw[11:0] - MA4_CODE) * 3'd5);
					ai_frac = cur[13:1] > 13'h0FFF ? 12'hFFF : cur[12:1];
				end
			end
			default:
				ai_frac = 12'h000;
		endcase
	endfunction

	function automatic logic [15:0] frac_hz(
		input logic [15:0] fmax,
		input logic [11:0] frac
	);
		logic [27:0] p;
		p = 28'(fmax) * 28'(frac);
		frac_hz = p[27:12];
	endfunction

	function automatic logic [15:0] pct_hz(
		input logic [15:0] fmax,
		input logic [10:0] pct
	);
		logic [26:0] p;
		p = 27'(fmax) * 27'(pct);
		p = p / 27'd1000;
		pct_hz = (p[26:16] != 11'h000) ? 16'hFFFF : p[15:0];
	endfunction

	function automatic logic [15:0] gain_hz(
		input logic [15:0] val,
		input logic [15:0] gain
	);
		logic [31:0] p;
		p = 32'(val) * 32'(gain);
		gain_hz = (p[31:24] != 8'h00) ? 16'hFFFF : p[23:8];
	endfunction

	// ==========================================================
	// Control decode
	logic [3:0] main_code;
	logic [3:0] alt_code;
	logic combine;
	logic min_detect;
	logic sleep_zero;
	logic retain;
	logic [2:0] ai_type;
	logic [3:0] ai2_fn;
	logic [3:0] pulse_fn;
	logic motor_two;
	ai_kind_e kind1;
	ai_kind_e kind2;
	logic [15:0] fmax;
	logic [15:0] upper_hz;
	logic [15:0] lower_hz;
	logic [15:0] ai1_hz;
	logic [15:0] ai2_hz;
	logic [15:0] analog_hz;
	logic [15:0] aux_hz;
	logic [15:0] pulse_hz;
	logic [15:0] mpg_hz;
	logic [15:0] main_hz;
	logic [15:0] alt_hz;
	logic [16:0] sum;
	logic [15:0] sel_hz;
	logic [15:0] lim_hz;
	logic [15:0] floor_hz;
	logic below;
	logic comm_mode;
	logic tick_hit;

	assign main_code = st.ctrl[F_MAIN+:4];
	assign alt_code = st.ctrl[F_ALT+:4];
	assign combine = st.ctrl[F_COMBINE];
	assign min_detect = st.ctrl[F_MINDET];
	assign sleep_zero = st.ctrl[F_SLEEP];
	assign retain = st.ctrl[F_RETAIN];
	assign ai_type = st.ctrl[F_AITYPE+:3];
	assign ai2_fn = st.ctrl[F_AI2FN+:4];
	assign pulse_fn = st.ctrl[F_PULSEFN+:4];
	assign motor_two = st.ctrl[F_MOTOR];
	assign comm_mode = (main_code == SRC_COMM) || (alt_code == SRC_COMM);
	assign tick_hit = (st.tick == TICK_W'(TICK_CYC - 1));

	// Input pair ranges by signal type
	always_comb
	begin
		case (ai_type) // R02
			3'd0:
			begin
				kind1 = AI_UNI;
				kind2 = AI_UNI;
			end
			3'd1:
			begin
				kind1 = AI_UNI;
				kind2 = AI_CUR;
			end
			3'd2:
			begin
				kind1 = AI_BIP;
				kind2 = AI_UNI;
			end
			3'd3:
			begin
				kind1 = AI_BIP;
				kind2 = AI_CUR;
			end
			3'd4:
			begin
				kind1 = AI_CUR;
				kind2 = AI_UNI;
			end
			3'd5:
			begin
				kind1 = AI_CUR;
				kind2 = AI_CUR;
			end
			default:
			begin
				kind1 = AI_UNI;
				kind2 = AI_UNI;
			end
		endcase
	end

	// ==========================================================
	// Source values
	assign fmax = motor_two ? st.fmax2 : st.fmax1; // R20
	assign upper_hz = pct_hz(fmax, st.upper); // R18
	assign lower_hz = pct_hz(fmax, st.lower); // R19
	assign ai1_hz = frac_hz(fmax, ai_frac(fe.ai1, kind1));
	assign ai2_hz = frac_hz(fmax, ai_frac(fe.ai2, kind2)); // R08
	assign analog_hz = (ai2_fn == AI2_ADD) ?
		((ai1_hz + ai2_hz < ai1_hz) ? 16'hFFFF : 16'(ai1_hz + ai2_hz)) :
		ai1_hz; // R03
	assign aux_hz = (ai2_fn == 4'h0) ? ai2_hz : 16'h0000; // R08 R09
	assign pulse_hz = (pulse_fn == 4'h0) ?
		gain_hz(fe.pulse_hz, st.pulse_gain) : 16'h0000; // R07
	assign mpg_hz = (gain_hz(fe.mpg_speed, st.mpg_mag) > st.mpg_limit) ?
		st.mpg_limit : gain_hz(fe.mpg_speed, st.mpg_mag); // R10

	function automatic logic [15:0] pick(
		input logic [3:0] code,
		input logic alt,
		input logic [15:0] keypad,
		input logic [15:0] stage0,
		input logic [15:0] analog,
		input logic [15:0] updown,
		input logic [15:0] comm,
		input logic [15:0] pulse,
		input logic [15:0] aux,
		input logic [15:0] handwheel_pulse_gen
	);
		case (code)
			SRC_KEYPAD: pick = alt ? stage0 : keypad; // R01
			SRC_ANALOG: pick = analog; // R03
			SRC_UPDOWN: pick = updown; // R04
			SRC_COMM: pick = comm; // R06
			SRC_PULSE: pick = pulse; // R07
			SRC_AUX: pick = aux; // R08
			SRC_MPG: pick = alt ? 16'h0000 : handwheel_pulse_gen; // R10
			default: pick = 16'h0000;
		endcase
	endfunction

	assign main_hz = pick(main_code, 1'b0, st.keypad, st.stage0,
		analog_hz, st.updown, st.comm, pulse_hz, aux_hz, mpg_hz);
	assign alt_hz = pick(alt_code, 1'b1, st.keypad, st.stage0,
		analog_hz, st.updown, st.comm, pulse_hz, aux_hz, mpg_hz);

	// ==========================================================
	// Combine, minimum handling, limits
	always_comb
	begin
		sum = {1'b0, main_hz} + {1'b0, alt_hz};
		if (combine) // R11
			sel_hz = sum[16] ? 16'hFFFF : sum[15:0];
		else
			sel_hz = main_hz;
		below = (sel_hz < st.fmin1);
		if (below && min_detect)
			sel_hz = st.fmin1; // R16
		lim_hz = sel_hz;
		if (lim_hz < lower_hz)
			lim_hz = lower_hz; // R19 R22
		if (lim_hz > upper_hz)
			lim_hz = upper_hz; // R18 R22
		floor_hz = sleep_zero ? 16'h0000 : lower_hz;
	end

	// ==========================================================
	// Next state
	always_comb
	begin
		next_st = st;
		next_st.save = 1'b0;
		next_st.inc_sync = {st.inc_sync[0], inc_pin};
		next_st.dec_sync = {st.dec_sync[0], dec_pin};
		next_st.tick = tick_hit ? '0 : TICK_W'(st.tick + 1'b1);
		// Up/down ramp on synchronised terminals
		if (tick_hit)
		begin
			if (st.inc_sync[1] && !st.dec_sync[1])
			begin
				if (st.updown < upper_hz)
					next_st.updown = 16'(st.updown + UPDOWN_STEP); // R04
			end
			else if (st.dec_sync[1] && !st.inc_sync[1])
			begin
				if (st.updown > lower_hz)
					next_st.updown = 16'(st.updown - UPDOWN_STEP); // R04
			end
		end
		// Communication value and persistence
		if (fe.comm_valid)
		begin
			next_st.comm = fe.comm_freq; // R06
			next_st.save = retain && comm_mode; // R14
		end
		else if (fe.restore_valid && retain && comm_mode)
			next_st.comm = fe.restore_freq; // R14
		// Output stage
		next_st.ref_q = lim_hz; // R23
		next_st.pid_q = (sleeping && fe.pid_in < floor_hz) ?
			floor_hz : fe.pid_in; // R17
		next_st.flg.same_source_error = combine &&
			(main_code == alt_code); // R12 R23
		next_st.flg.limit_range_error = (st.upper < st.lower); // R21
		next_st.flg.below_min_warning = below && !min_detect; // R15
		next_st.flg.comm_shown = comm_mode; // R13
		// Register writes
		if (write_strobe)
		begin
			case (address)
				REG_CTRL: next_st.ctrl = write_data[CTRL_W-1:0];
				REG_KEYPAD: next_st.keypad = write_data[15:0];
				REG_STAGE0: next_st.stage0 = write_data[15:0];
				REG_UPPER:
				begin
					if (write_data[10:0] >= PCT_UPPER_MIN &&
						write_data[10:0] <= PCT_MAX)
						next_st.upper = write_data[10:0]; // R18
				end
				REG_LOWER:
				begin
					if (write_data[10:0] <= PCT_MAX)
						next_st.lower = write_data[10:0]; // R19
				end
				REG_FMAX1: next_st.fmax1 = write_data[15:0];
				REG_FMAX2: next_st.fmax2 = write_data[15:0];
				REG_FMIN1: next_st.fmin1 = write_data[15:0];
				REG_PULSE_GAIN: next_st.pulse_gain = write_data[15:0];
				REG_MPG_MAG: next_st.mpg_mag = write_data[15:0];
				REG_MPG_LIMIT: next_st.mpg_limit = write_data[15:0];
				default: next_st.ctrl = st.ctrl;
			endcase
		end
		// Register reads
		next_st.rdata = '0;
		if (read_strobe)
		begin
			case (address)
				REG_CTRL: next_st.rdata = DATA_W'(st.ctrl);
				REG_KEYPAD: next_st.rdata = DATA_W'(st.keypad);
				REG_STAGE0: next_st.rdata = DATA_W'(st.stage0);
				REG_UPPER: next_st.rdata = DATA_W'(st.upper);
				REG_LOWER: next_st.rdata = DATA_W'(st.lower);
				REG_FMAX1: next_st.rdata = DATA_W'(st.fmax1);
				REG_FMAX2: next_st.rdata = DATA_W'(st.fmax2);
				REG_FMIN1: next_st.rdata = DATA_W'(st.fmin1);
				REG_PULSE_GAIN: next_st.rdata = DATA_W'(st.pulse_gain);
				REG_MPG_MAG: next_st.rdata = DATA_W'(st.mpg_mag);
				REG_MPG_LIMIT: next_st.rdata = DATA_W'(st.mpg_limit);
				REG_COMM:
					next_st.rdata = comm_mode ?
						DATA_W'(st.comm) : '0; // R13
				REG_REF: next_st.rdata = DATA_W'(st.ref_q);
				REG_STATUS: next_st.rdata = DATA_W'(st.flg);
				default: next_st.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st <= '0;
			st.ctrl <= CTRL_RST;
			st.keypad <= FREQ_RST;
			st.stage0 <= FREQ_RST;
			st.upper <= UPPER_RST;
			st.lower <= LOWER_RST;
			st.fmax1 <= FMAX_RST;
			st.fmax2 <= FMAX_RST;
			st.fmin1 <= FMIN_RST;
			st.pulse_gain <= GAIN_RST;
			st.mpg_mag <= GAIN_RST;
			st.mpg_limit <= LIMIT_RST;
		end
		else
			st <= next_st;
	end

	assign read_data = st.rdata;
	assign freq_ref = st.ref_q;
	assign pid_bounded = st.pid_q;
	assign flags = st.flg;
	assign comm_save = st.save;
endmodule // freq_ref_selector

`default_nettype wire

// ===== pkg/freq_ref_pkg.sv
// Package: register map, reset values and carriers of the reference selector
package freq_ref_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int FREQ_W = 16;
	localparam int PCT_W = 11;
	// Register indices
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_KEYPAD = 4'h1;
	localparam logic [3:0] REG_STAGE0 = 4'h2;
	localparam logic [3:0] REG_UPPER = 4'h3;
	localparam logic [3:0] REG_LOWER = 4'h4;
	localparam logic [3:0] REG_FMAX1 = 4'h5;
	localparam logic [3:0] REG_FMAX2 = 4'h6;
	localparam logic [3:0] REG_FMIN1 = 4'h7;
	localparam logic [3:0] REG_PULSE_GAIN = 4'h8;
	localparam logic [3:0] REG_MPG_MAG = 4'h9;
	localparam logic [3:0] REG_MPG_LIMIT = 4'hA;
	localparam logic [3:0] REG_COMM = 4'hB;
	localparam logic [3:0] REG_REF = 4'hC;
	localparam logic [3:0] REG_STATUS = 4'hD;
	// Control field positions
	localparam int F_MAIN = 0;
	localparam int F_ALT = 4;
	localparam int F_COMBINE = 8;
	localparam int F_MINDET = 9;
	localparam int F_SLEEP = 10;
	localparam int F_RETAIN = 11;
	localparam int F_AITYPE = 12;
	localparam int F_AI2FN = 16;
	localparam int F_PULSEFN = 20;
	localparam int F_MOTOR = 24;
	localparam int CTRL_W = 25;
	// Values after reset
	localparam logic [CTRL_W-1:0] CTRL_RST = 25'h0001000;
	localparam logic [15:0] FREQ_RST = 16'h0000;
	localparam logic [15:0] FMAX_RST = 16'h1770;
	localparam logic [15:0] FMIN_RST = 16'h0096;
	localparam logic [10:0] UPPER_RST = 11'h3E8;
	localparam logic [10:0] LOWER_RST = 11'h000;
	localparam logic [15:0] GAIN_RST = 16'h0100;
	localparam logic [15:0] LIMIT_RST = 16'hFFFF;
	// Fixed codes
	localparam logic [3:0] SRC_KEYPAD = 4'h0;
	localparam logic [3:0] SRC_ANALOG = 4'h1;
	localparam logic [3:0] SRC_UPDOWN = 4'h2;
	localparam logic [3:0] SRC_COMM = 4'h3;
	localparam logic [3:0] SRC_PULSE = 4'h4;
	localparam logic [3:0] SRC_AUX = 4'h7;
	localparam logic [3:0] SRC_MPG = 4'h8;
	localparam logic [3:0] AI2_ADD = 4'hA;
	localparam logic [10:0] PCT_MAX = 11'h442;
	localparam logic [10:0] PCT_UPPER_MIN = 11'h001;
	localparam logic [11:0] MA4_CODE = 12'h19A;
	localparam logic [15:0] UPDOWN_STEP = 16'h0001;
	// Up/down ramp tick
	localparam int CLK_NS = 20;
	localparam int UPDOWN_TICK_NS = 1000000;
	localparam int UPDOWN_TICK_CYC = UPDOWN_TICK_NS / CLK_NS;
	localparam int TICK_W = 16;

	typedef enum logic [1:0] {
		AI_UNI = 2'b00,
		AI_BIP = 2'b01,
		AI_CUR = 2'b10
	} ai_kind_e;

	typedef struct packed {
		logic signed [11:0] ai1;
		logic signed [11:0] ai2;
		logic [15:0] pulse_hz;
		logic [15:0] mpg_speed;
		logic [15:0] comm_freq;
		logic comm_valid;
		logic [15:0] restore_freq;
		logic restore_valid;
		logic [15:0] pid_in;
	} fe_in_s;

	typedef struct packed {
		logic same_source_error;
		logic limit_range_error;
		logic below_min_warning;
		logic comm_shown;
	} flags_s;
endpackage
